// ### core/pca_pkg.sv
package pca_pkg;

  // ==========================================================
  // call-data sram
  localparam int RAM_DEPTH = 96;
  localparam logic [6:0] RAM_LAST = 7'h5f;
  localparam logic [6:0] RAM_PTR_RST = 7'h00;

  // ==========================================================
  // nonvolatile store
  localparam int NVM_BYTES = 48;
  localparam int NVM_COLS = 6;
  localparam logic [2:0] NVM_COL_LAST = 3'h5;
  localparam logic [5:0] NVM_ROW_STRIDE = 6'h06;
  localparam int NVM_PTR_COL_LSB = 0;
  localparam int NVM_PTR_ROW_LSB = 3;
  localparam int SPF_BYTE0 = 0;
  localparam int SPF_BYTE1 = 1;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_WR_PTR = 8'h06;
  localparam logic [7:0] OFS_NVM_PTR = 8'h07;
  localparam logic [7:0] OFS_RD_PTR = 8'h08;
  localparam logic [7:0] OFS_RAM_DATA = 8'h09;
  localparam logic [7:0] OFS_NVM_DATA = 8'h0a;
  localparam logic [7:0] READ_FILL = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_MHZ = 200;
  localparam int PROG_TIME_US = 7500;
  localparam int PROG_CYC = PROG_TIME_US * CLK_FREQ_MHZ;
  localparam int PROG_CNT_W = 21;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    PG_IDLE = 3'b001,
    PG_FILL = 3'b010,
    PG_BURN = 3'b100
  } pca_pgm_t;

  typedef struct packed {
    logic voltage_converter;
    logic synth_load;
    logic [1:0] bit_rate;
    logic [1:0] osc_settle;
    logic [1:0] rx_settle;
    logic data_invert;
    logic continuous_decoding;
    logic [3:0] batch_number;
    logic cycle_15;
    logic protocol_alt;
  } pca_spf_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pca_req_t;

  typedef struct packed {
    logic [RAM_DEPTH-1:0][7:0] ram;
    logic [NVM_BYTES-1:0][7:0] nvm;
    logic [NVM_COLS-1:0][7:0] row_buf;
    logic [6:0] wp;
    logic [6:0] rp;
    logic nonempty;
    logic equal_flag;
    logic [2:0] col;
    logic [2:0] row;
    logic [2:0] burn_row;
    pca_pgm_t pgm;
    logic [PROG_CNT_W-1:0] burn_cnt;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic start_s1;
    logic start_s2;
    logic start_seen;
    logic stop_s1;
    logic stop_s2;
    logic stop_seen;
    logic ack_tgl;
    logic [7:0] rdata;
    logic stretch;
  } pca_core_t;

  typedef struct packed {
    pca_req_t req;
    logic req_tgl;
    logic pending;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic start_tgl;
    logic stop_tgl;
    logic ack;
    logic [7:0] rdata;
  } pca_link_t;

endpackage

// ### core/pca_access.sv
`timescale 1ns/1ps
`default_nettype none

module pca_access
  import pca_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // core clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // receive path and control
  input wire logic RX_BYTE_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic PROG_ENABLE,
  input wire logic STATUS_READ,
  // status and configuration
  output logic BUF_NONEMPTY,
  output logic PTR_EQUAL,
  output logic PROG_BUSY,
  output pca_spf_t SPF_CFG,
  // clock stretch pin
  output logic SCL_O,
  output logic SCL_OE,
  // link side register access
  input wire logic LCLK,
  input wire logic L_REQ,
  input wire logic L_WR,
  input wire logic [7:0] L_ADDR,
  input wire logic [7:0] L_WDATA,
  input wire logic L_START,
  input wire logic L_STOP,
  output logic L_BUSY,
  output logic L_ACK,
  output logic [7:0] L_RDATA
);

  // ==========================================================
  // state
  pca_core_t c_r;
  pca_core_t c_nxt;
  pca_link_t l_r;
  pca_link_t l_nxt;

  logic rx_wr;
  logic rd_adv;
  logic rp_load;
  logic eq_set;
  logic req_new;
  logic [5:0] rd_idx;
  logic [7:0] rdata_v;
  logic [5:0][7:0] buf_v;

  function automatic logic [5:0] nvm_idx(input logic [2:0] row, input logic [2:0] col);
    nvm_idx = ({3'h0, row} * NVM_ROW_STRIDE) + {3'h0, col};
  endfunction

  // ==========================================================
  // core domain next state
  always_comb begin
    c_nxt = c_r;
    rx_wr = 1'b0;
    rd_adv = 1'b0;
    rp_load = 1'b0;
    eq_set = 1'b0;
    rdata_v = READ_FILL;
    buf_v = c_r.row_buf;
    rd_idx = nvm_idx(c_r.row, c_r.col);
    req_new = (c_r.req_s2 != c_r.req_seen);

    c_nxt.req_s1 = l_r.req_tgl;
    c_nxt.req_s2 = c_r.req_s1;
    c_nxt.start_s1 = l_r.start_tgl;
    c_nxt.start_s2 = c_r.start_s1;
    c_nxt.stop_s1 = l_r.stop_tgl;
    c_nxt.stop_s2 = c_r.stop_s1;

    if (RX_BYTE_VALID) begin
      rx_wr = 1'b1;
      c_nxt.ram[c_r.wp] = RX_BYTE;
      c_nxt.wp = (c_r.wp == RAM_LAST) ? RAM_PTR_RST : c_r.wp + 7'h01;
    end

    // register requests wait while a row is programming
    if (req_new && c_r.pgm != PG_BURN) begin
      c_nxt.req_seen = c_r.req_s2;
      c_nxt.ack_tgl = ~c_r.ack_tgl;
      if (!l_r.req.wr) begin
        unique case (l_r.req.addr)
          OFS_WR_PTR: rdata_v = {1'b0, c_r.wp};
          OFS_NVM_PTR: rdata_v = {2'b00, c_r.row, c_r.col};
          OFS_RD_PTR: rdata_v = {1'b0, c_r.rp};
          OFS_RAM_DATA: begin
            rdata_v = c_r.ram[c_r.rp];
            rd_adv = 1'b1;
          end
          OFS_NVM_DATA: begin
            rdata_v = c_r.nvm[rd_idx];
            c_nxt.col = (c_r.col >= NVM_COL_LAST) ? 3'h0 : c_r.col + 3'h1;
            c_nxt.row = (c_r.col >= NVM_COL_LAST) ? c_r.row + 3'h1 : c_r.row;
          end
          default: rdata_v = READ_FILL;
        endcase
      end else begin
        unique case (l_r.req.addr)
          OFS_NVM_PTR: begin
            c_nxt.col = (l_r.req.wdata[2:0] > NVM_COL_LAST) ? 3'h0 : l_r.req.wdata[2:0];
            c_nxt.row = l_r.req.wdata[NVM_PTR_ROW_LSB +: 3];
            if (c_r.pgm == PG_FILL) begin
              c_nxt.pgm = PG_IDLE;
            end
          end
          OFS_RD_PTR: begin
            c_nxt.rp = l_r.req.wdata[6:0];
            rp_load = 1'b1;
          end
          OFS_NVM_DATA: begin
            if (PROG_ENABLE) begin
              if (c_r.pgm == PG_IDLE || c_r.col == 3'h0) begin
                buf_v = '0;
                c_nxt.burn_row = c_r.row;
              end
              buf_v[c_r.col] = l_r.req.wdata;
              c_nxt.row_buf = buf_v;
              c_nxt.pgm = PG_FILL;
              if (c_r.col >= NVM_COL_LAST) begin
                c_nxt.pgm = PG_BURN;
                c_nxt.burn_cnt = PROG_CNT_W'(PROG_CYCLES - 1);
              end
            end
            c_nxt.col = (c_r.col >= NVM_COL_LAST) ? 3'h0 : c_r.col + 3'h1;
            c_nxt.row = (c_r.col >= NVM_COL_LAST) ? c_r.row + 3'h1 : c_r.row;
          end
          default: rdata_v = READ_FILL;
        endcase
      end
      c_nxt.rdata = rdata_v;
    end

    if (rd_adv) begin
      c_nxt.rp = (c_r.rp == RAM_LAST) ? RAM_PTR_RST : c_r.rp + 7'h01;
    end

    if (rx_wr || rd_adv || rp_load) begin
      eq_set = (c_nxt.wp == c_nxt.rp);
      c_nxt.nonempty = !eq_set || (rx_wr && !rd_adv && !rp_load);
    end
    c_nxt.equal_flag = eq_set ? 1'b1 : (STATUS_READ ? 1'b0 : c_r.equal_flag);

    if (c_r.stop_s2 != c_r.stop_seen) begin
      c_nxt.stop_seen = c_r.stop_s2;
      if (c_r.pgm == PG_FILL) begin
        c_nxt.pgm = PG_IDLE;
      end
    end

    // hold SCL on a new transfer while a row is programming
    if (c_r.start_s2 != c_r.start_seen) begin
      c_nxt.start_seen = c_r.start_s2;
      if (c_r.pgm == PG_BURN) begin
        c_nxt.stretch = 1'b1;
      end
    end

    unique case (c_r.pgm)
      PG_IDLE: begin
      end
      PG_FILL: begin
      end
      PG_BURN: begin
        if (c_r.burn_cnt == '0) begin
          for (int i = 0; i < NVM_COLS; i++) begin
            c_nxt.nvm[nvm_idx(c_r.burn_row, 3'(i))] = c_r.row_buf[i];
          end
          c_nxt.pgm = PG_IDLE;
          c_nxt.stretch = 1'b0;
        end else begin
          c_nxt.burn_cnt = c_r.burn_cnt - PROG_CNT_W'(1);
        end
      end
      default: c_nxt.pgm = PG_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      c_r <= '0;
      c_r.pgm <= PG_IDLE;
    end else if (CE) begin
      c_r <= c_nxt;
    end
  end

  // ==========================================================
  // link domain next state
  always_comb begin
    l_nxt = l_r;
    l_nxt.ack = 1'b0;
    l_nxt.ack_s1 = c_r.ack_tgl;
    l_nxt.ack_s2 = l_r.ack_s1;
    if (l_r.pending && l_r.ack_s2 != l_r.ack_seen) begin
      l_nxt.ack_seen = l_r.ack_s2;
      l_nxt.pending = 1'b0;
      l_nxt.ack = 1'b1;
      l_nxt.rdata = c_r.rdata;
    end else if (!l_r.pending && L_REQ) begin
      l_nxt.req.wr = L_WR;
      l_nxt.req.addr = L_ADDR;
      l_nxt.req.wdata = L_WDATA;
      l_nxt.req_tgl = ~l_r.req_tgl;
      l_nxt.pending = 1'b1;
    end
    if (L_START) begin
      l_nxt.start_tgl = ~l_r.start_tgl;
    end
    if (L_STOP) begin
      l_nxt.stop_tgl = ~l_r.stop_tgl;
    end
  end

  always_ff @(posedge LCLK or negedge RSTN) begin
    if (!RSTN) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign BUF_NONEMPTY = c_r.nonempty;
  assign PTR_EQUAL = c_r.equal_flag;
  assign PROG_BUSY = (c_r.pgm == PG_BURN);
  assign SPF_CFG = pca_spf_t'({c_r.nvm[SPF_BYTE1], c_r.nvm[SPF_BYTE0]});
  assign SCL_O = 1'b0;
  assign SCL_OE = c_r.stretch;
  assign L_BUSY = l_r.pending;
  assign L_ACK = l_r.ack;
  assign L_RDATA = l_r.rdata;

endmodule

`default_nettype wire

// ### verif/pca_access_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pca_access_sva
  import pca_pkg::*;
#(
  parameter int PROG_CYCLES = 400
) (
  // clocks and reset
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic LCLK,
  // link side
  input wire logic L_REQ,
  input wire logic L_WR,
  input wire logic L_BUSY,
  input wire logic L_ACK,
  input wire logic [7:0] L_RDATA,
  // programming and stretch
  input wire logic PROG_BUSY,
  input wire logic SCL_O,
  input wire logic SCL_OE
);
  localparam int BURN_MAX = PROG_CYCLES + 4;
  // ==========================================================
  // core domain
  AST_SCL_LOW: assert property (@(posedge CLK) disable iff (!RSTN) SCL_OE |-> SCL_O == 1'b0)
    else $error("stretch pin not driven low");
  AST_OE_IN_BURN: assert property (@(posedge CLK) disable iff (!RSTN) SCL_OE |-> PROG_BUSY)
    else $error("stretch outside programming");
  AST_SCL_RELEASE: assert property (@(posedge CLK) disable iff (!RSTN) $fell(PROG_BUSY) |-> !SCL_OE)
    else $error("stretch kept after programming");
  AST_BURN_MIN: assert property (@(posedge CLK) disable iff (!RSTN) $rose(PROG_BUSY) |-> PROG_BUSY [*8])
    else $error("programming pause too short");
  AST_BURN_MAX: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(PROG_BUSY) |-> ##[1:BURN_MAX] !PROG_BUSY) else $error("programming pause too long");
  // ==========================================================
  // link domain
  AST_ACK_PULSE: assert property (@(posedge LCLK) disable iff (!RSTN) L_ACK |=> !L_ACK)
    else $error("ack longer than one cycle");
  AST_BUSY_CAUSE: assert property (@(posedge LCLK) disable iff (!RSTN) $rose(L_BUSY) |-> $past(L_REQ))
    else $error("busy without request");
  AST_WR_RDATA: assert property (@(posedge LCLK) disable iff (!RSTN)
    L_ACK && L_WR && !L_BUSY |-> L_RDATA == 8'h00) else $error("write answered with data");
endmodule
bind pca_access pca_access_sva #(.PROG_CYCLES(PROG_CYCLES)) sva_u (.CLK(CLK), .RSTN(RSTN), .LCLK(LCLK),
  .L_REQ(L_REQ), .L_WR(L_WR), .L_BUSY(L_BUSY), .L_ACK(L_ACK), .L_RDATA(L_RDATA),
  .PROG_BUSY(PROG_BUSY), .SCL_O(SCL_O), .SCL_OE(SCL_OE));
`default_nettype wire

// ### verif/pca_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pca_host_model (
  // link clock and answer
  input wire logic LCLK,
  input wire logic L_ACK,
  input wire logic [7:0] L_RDATA,
  // request and bus events
  output logic L_REQ,
  output logic L_WR,
  output logic [7:0] L_ADDR,
  output logic [7:0] L_WDATA,
  output logic L_START,
  output logic L_STOP
);
  initial begin
    L_REQ = 1'b0;
    L_WR = 1'b0;
    L_ADDR = 8'h00;
    L_WDATA = 8'h00;
    L_START = 1'b0;
    L_STOP = 1'b0;
  end
  // ==========================================================
  // one register transfer, request pulsed one cycle, then wait for ack
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge LCLK);
    L_REQ <= 1'b1;
    L_WR <= w;
    L_ADDR <= a;
    L_WDATA <= d;
    @(posedge LCLK);
    L_REQ <= 1'b0;
    n = 0;
    while (L_ACK !== 1'b1 && n < 200) begin
      @(posedge LCLK);
      n++;
    end
    q = (n < 200) ? L_RDATA : 8'hxx;
    L_WDATA <= ~d;
  endtask
  // ==========================================================
  // start or stop condition
  task automatic mark(input logic stop);
    @(posedge LCLK);
    L_START <= !stop;
    L_STOP <= stop;
    @(posedge LCLK);
    L_START <= 1'b0;
    L_STOP <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench
  import pca_pkg::*;
;
  logic CLK, RSTN, CE, LCLK, RX_BYTE_VALID, PROG_ENABLE, STATUS_READ, L_REQ, L_WR, L_START, L_STOP;
  logic BUF_NONEMPTY, PTR_EQUAL, PROG_BUSY, SCL_O, SCL_OE, L_BUSY, L_ACK;
  logic [7:0] RX_BYTE, L_ADDR, L_WDATA, L_RDATA;
  pca_spf_t SPF_CFG;
  int miscompares = 0;
  int cmp_count = 0;
  pca_access #(.PROG_CYCLES(400)) dut_u (.CLK(CLK), .RSTN(RSTN), .CE(CE), .RX_BYTE_VALID(RX_BYTE_VALID),
    .RX_BYTE(RX_BYTE), .PROG_ENABLE(PROG_ENABLE), .STATUS_READ(STATUS_READ), .BUF_NONEMPTY(BUF_NONEMPTY),
    .PTR_EQUAL(PTR_EQUAL), .PROG_BUSY(PROG_BUSY), .SPF_CFG(SPF_CFG), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .LCLK(LCLK), .L_REQ(L_REQ), .L_WR(L_WR), .L_ADDR(L_ADDR), .L_WDATA(L_WDATA), .L_START(L_START),
    .L_STOP(L_STOP), .L_BUSY(L_BUSY), .L_ACK(L_ACK), .L_RDATA(L_RDATA));
  pca_host_model host_u (.LCLK(LCLK), .L_ACK(L_ACK), .L_RDATA(L_RDATA), .L_REQ(L_REQ), .L_WR(L_WR),
    .L_ADDR(L_ADDR), .L_WDATA(L_WDATA), .L_START(L_START), .L_STOP(L_STOP));
  // ==========================================================
  // helpers
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host_u.access(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_u.access(1'b1, a, d, q);
    `CHK(q, READ_FILL)
  endtask
  task automatic rx(input logic [7:0] b);
    @(posedge CLK);
    RX_BYTE_VALID <= 1'b1;
    RX_BYTE <= b;
    @(posedge CLK);
    RX_BYTE_VALID <= 1'b0;
    RX_BYTE <= ~b;
  endtask
  task automatic row(input logic [7:0] p, input logic [7:0] b);
    wr(OFS_NVM_PTR, p);
    for (int i = 0; i < 6; i++) wr(OFS_NVM_DATA, 8'(b + i));
  endtask
  // ==========================================================
  // call-data sram
  task automatic t_ram;
    rd(OFS_WR_PTR, 8'h00);
    for (int i = 0; i < 3; i++) rx(8'(8'h30 + i));
    @(posedge CLK);
    `CHK(BUF_NONEMPTY, 1'b1)
    wr(OFS_WR_PTR, 8'h40);
    rd(OFS_WR_PTR, 8'h03);
    for (int i = 0; i < 3; i++) rd(OFS_RAM_DATA, 8'(8'h30 + i));
    rd(OFS_RD_PTR, 8'h03);
    `CHK(BUF_NONEMPTY, 1'b0)
    `CHK(PTR_EQUAL, 1'b1)
    @(posedge CLK);
    STATUS_READ <= 1'b1;
    @(posedge CLK);
    STATUS_READ <= 1'b0;
    @(posedge CLK);
    `CHK(PTR_EQUAL, 1'b0)
    wr(OFS_RD_PTR, 8'hdf);
    rd(OFS_RD_PTR, 8'h5f);
    rd(OFS_RAM_DATA, 8'h00);
    rd(OFS_RD_PTR, 8'h00);
    rd(8'h0b, 8'h00);
    for (int i = 0; i < 93; i++) rx(8'(i));
    rd(OFS_WR_PTR, 8'h00);
    `CHK(BUF_NONEMPTY, 1'b1)
    `CHK(PTR_EQUAL, 1'b1)
    wr(OFS_RD_PTR, 8'h5f);
    rd(OFS_RAM_DATA, 8'h5c);
    @(posedge CLK);
    CE <= 1'b0;
    rx(8'h99);
    CE <= 1'b1;
    rd(OFS_WR_PTR, 8'h00);
  endtask
  // ==========================================================
  // nonvolatile store
  task automatic t_nvm;
    int n;
    wr(OFS_NVM_PTR, 8'hef);
    rd(OFS_NVM_PTR, 8'h28);
    wr(OFS_NVM_DATA, 8'h55);
    rd(OFS_NVM_PTR, 8'h29);
    wr(OFS_NVM_PTR, 8'h28);
    rd(OFS_NVM_DATA, 8'h00);
    @(posedge CLK);
    PROG_ENABLE <= 1'b1;
    row(8'h28, 8'ha0);
    host_u.mark(1'b0);
    repeat (8) @(posedge CLK);
    `CHK(SCL_OE, 1'b1)
    n = 0;
    while (PROG_BUSY === 1'b1 && n < 1000) begin
      @(posedge CLK);
      n++;
    end
    `CHK(SCL_OE, 1'b0)
    `CHK(PROG_BUSY, 1'b0)
    rd(OFS_NVM_PTR, 8'h30);
    wr(OFS_NVM_PTR, 8'h28);
    for (int i = 0; i < 6; i++) rd(OFS_NVM_DATA, 8'(8'ha0 + i));
    wr(OFS_NVM_PTR, 8'h3d);
    wr(OFS_NVM_DATA, 8'h77);
    rd(OFS_NVM_PTR, 8'h00);
    wr(OFS_NVM_PTR, 8'h38);
    for (int i = 0; i < 5; i++) rd(OFS_NVM_DATA, 8'h00);
    rd(OFS_NVM_DATA, 8'h77);
    wr(OFS_NVM_PTR, 8'h28);
    for (int i = 0; i < 3; i++) wr(OFS_NVM_DATA, 8'h11);
    host_u.mark(1'b1);
    wr(OFS_NVM_PTR, 8'h28);
    for (int i = 0; i < 6; i++) rd(OFS_NVM_DATA, 8'(8'ha0 + i));
    row(8'h00, 8'h5c);
    rd(OFS_NVM_PTR, 8'h08);
    `CHK(SPF_CFG, 16'h5d5c)
    `CHK(SPF_CFG.batch_number, 4'h7)
    `CHK(SPF_CFG.bit_rate, 2'h1)
    `CHK(SPF_CFG.continuous_decoding, 1'b1)
    `CHK(SPF_CFG.protocol_alt, 1'b0)
    `CHK(SPF_CFG.synth_load, 1'b1)
    wr(OFS_NVM_PTR, 8'h04);
    rd(OFS_NVM_DATA, 8'h60);
    rd(OFS_NVM_DATA, 8'h61);
    @(posedge CLK);
    PROG_ENABLE <= 1'b0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clocks, reset, sequence, watchdog
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial begin
    LCLK = 1'b0;
    #13;
    forever #40 LCLK = ~LCLK;
  end
  initial begin
    RSTN = 1'b0;
    CE = 1'b1;
    RX_BYTE_VALID = 1'b0;
    RX_BYTE = 8'h00;
    PROG_ENABLE = 1'b0;
    STATUS_READ = 1'b0;
    repeat (10) @(posedge LCLK);
    @(posedge CLK);
    RSTN <= 1'b1;
    t_ram();
    t_nvm();
    summarize();
  end
  initial begin
    #300000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
